// ### rtl/pse_mask_pkg.sv
// Constants and carrier types for the global mask and configuration block.
// Assumes one device clock and a command-code register port from the serial target.
package pse_mask_pkg;

   localparam int         NUM_CH          = 8;
   localparam logic [7:0] CMD_GLOBAL_MASK = 8'h17;
   localparam logic [7:0] MASK_RESET      = 8'h80;

   // Field positions in the global mask byte
   localparam int BIT_IRQ_GATE     = 7;
   localparam int BIT_SPARE_HI     = 6;
   localparam int BIT_ACCESS_WIDTH = 5;
   localparam int BIT_PRIO_WIDTH   = 4;
   localparam int BIT_CLASS_FILT   = 3;
   localparam int BIT_DET_FILT     = 2;

   // Per-channel result report from a discovery engine
   typedef struct packed
   {
      logic [NUM_CH-1:0]      done;
      logic [NUM_CH-1:0][3:0] result;
   } report_t;

   // Per-channel timing fault pulses
   typedef struct packed
   {
      logic [NUM_CH-1:0] current_limit_timeout_fault;
      logic [NUM_CH-1:0] overload_timeout_fault;
      logic [NUM_CH-1:0] maintain_power_dropout_fault;
      logic [NUM_CH-1:0] startup_timeout_fault;
   } fault_t;

   // Whole state of the block
   typedef struct packed
   {
      logic [7:0]             mask_a;
      logic [7:0]             mask_b;
      logic [NUM_CH-1:0][3:0] prev_class;
      logic [NUM_CH-1:0][3:0] prev_det;
      logic [NUM_CH-1:0]      class_seen;
      logic [NUM_CH-1:0]      det_seen;
      logic [NUM_CH-1:0]      class_event_flag;
      logic [NUM_CH-1:0]      detection_event_flag;
      logic [NUM_CH-1:0]      power_good_clear;
      logic [NUM_CH-1:0]      power_enable_clear;
      logic [NUM_CH-1:0][2:0] shutdown_prio;
      logic                   irq_n;
      logic [15:0]            rdata;
      logic                   rvalid;
   } state_t;

endpackage : pse_mask_pkg

// ### rtl/pse_general_mask_config.sv
// Global mask and configuration register of the eight-channel controller.
// Assumes the serial target decodes addresses and presents command-code accesses,
// and that event, priority and discovery logic sit on the same clock.
`timescale 1ns/1ps

module pse_general_mask_config
   import pse_mask_pkg::*;
(
   // Clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   rst,
   // Command-code register port
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   input  wire logic [7:0]             reg_cmd,
   input  wire logic                   reg_group_b,
   input  wire logic [15:0]            reg_wdata,
   output      logic [15:0]            reg_rdata,
   output      logic                   reg_rvalid,
   // Interrupt sources, low byte channels 1-4, high byte channels 5-8
   input  wire logic [15:0]            irq_source,
   input  wire logic [15:0]            irq_enable,
   output      logic                   irq_n,
   // Serial access mode
   output      logic                   access_width_select,
   // Shutdown priority
   input  wire logic [NUM_CH-1:0]      prio_1bit,
   input  wire logic [NUM_CH-1:0][2:0] prio_3bit,
   output      logic                   priority_width_select,
   output      logic [NUM_CH-1:0][2:0] shutdown_prio,
   // Discovery reports and event flag set pulses
   input  wire report_t                class_report,
   input  wire report_t                det_report,
   output      logic [NUM_CH-1:0]      class_event_flag,
   output      logic [NUM_CH-1:0]      detection_event_flag,
   // Power status clearing
   input  wire fault_t                 faults,
   output      logic [NUM_CH-1:0]      power_good_clear,
   output      logic [NUM_CH-1:0]      power_enable_clear
);

   ////////////////////////////////////////////////////////////////////////////////
   // State

   state_t q;
   state_t next_q;

   // Channel lives in the instance for channels 1-4 when below four
   function automatic logic [7:0] owner_mask(input state_t s, input int ch);
      owner_mask = (ch < 4) ? s.mask_a : s.mask_b;
   endfunction : owner_mask

   // Filtered event decision shared by class and detection paths
   function automatic logic event_fires(input logic done, input logic filt,
                                        input logic seen, input logic [3:0] now,
                                        input logic [3:0] prev);
      event_fires = done && (!filt || !seen || (now != prev));
   endfunction : event_fires

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   // Decode helpers; own is the mask byte of the instance holding a channel
   logic       hit;
   logic       wide;
   logic [7:0] own;

   always_comb
   begin
      next_q = q;
      hit    = (reg_cmd == CMD_GLOBAL_MASK);
      wide   = q.mask_a[BIT_ACCESS_WIDTH];
      own    = 8'h00;

      // Register writes; 16-bit mode carries both instances in one access
      if (reg_wr && hit)
      begin
         if (wide)
         begin
            next_q.mask_a = reg_wdata[7:0];
            next_q.mask_b = reg_wdata[15:8];
         end
         else if (!reg_group_b)
         begin
            next_q.mask_a = reg_wdata[7:0];
         end
         else
         begin
            next_q.mask_b = reg_wdata[7:0];
         end
      end

      // Reads answer one cycle later; other commands belong elsewhere
      next_q.rvalid = reg_rd && hit;
      if (reg_rd && hit)
      begin
         if (wide)
         begin
            next_q.rdata = {q.mask_b, q.mask_a};
         end
         else if (!reg_group_b)
         begin
            next_q.rdata = {8'h00, q.mask_a};
         end
         else
         begin
            next_q.rdata = {8'h00, q.mask_b};
         end
      end

      // Each gate only blocks its own group's sources at the pin
      next_q.irq_n = !((q.mask_a[BIT_IRQ_GATE] && |(irq_source[7:0] & irq_enable[7:0]))
                    || (q.mask_b[BIT_IRQ_GATE] && |(irq_source[15:8] & irq_enable[15:8])));

      for (int ch = 0; ch < NUM_CH; ch++)
      begin
         // Channels 1-4 follow instance a, channels 5-8 instance b
         own = owner_mask(q, ch);

         // Event flags ignore the interrupt gate entirely
         next_q.class_event_flag[ch] = event_fires(class_report.done[ch],
            own[BIT_CLASS_FILT], q.class_seen[ch],
            class_report.result[ch], q.prev_class[ch]);
         next_q.detection_event_flag[ch] = event_fires(det_report.done[ch],
            own[BIT_DET_FILT], q.det_seen[ch],
            det_report.result[ch], q.prev_det[ch]);

         // Remember last result so the filter can compare
         if (class_report.done[ch])
         begin
            next_q.prev_class[ch] = class_report.result[ch];
            next_q.class_seen[ch] = 1'b1;
         end
         if (det_report.done[ch])
         begin
            next_q.prev_det[ch] = det_report.result[ch];
            next_q.det_seen[ch] = 1'b1;
         end

         // Any timing fault drops both power status bits
         next_q.power_good_clear[ch] = faults.current_limit_timeout_fault[ch]
            || faults.overload_timeout_fault[ch]
            || faults.maintain_power_dropout_fault[ch]
            || faults.startup_timeout_fault[ch];
         next_q.power_enable_clear[ch] = next_q.power_good_clear[ch];

         // Priority source follows the instance that owns the channel
         if (own[BIT_PRIO_WIDTH])
         begin
            next_q.shutdown_prio[ch] = prio_3bit[ch];
         end
         else
         begin
            next_q.shutdown_prio[ch] = {2'b00, prio_1bit[ch]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register

   // Previous results start unseen so the first report always counts
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         q        <= '0;
         q.mask_a <= MASK_RESET;
         q.mask_b <= MASK_RESET;
         q.irq_n  <= 1'b1;
      end
      else
      begin
         q <= next_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from flops

   assign reg_rdata             = q.rdata;
   assign reg_rvalid            = q.rvalid;
   assign irq_n                 = q.irq_n;
   assign access_width_select   = q.mask_a[BIT_ACCESS_WIDTH];
   assign priority_width_select = q.mask_a[BIT_PRIO_WIDTH];
   assign shutdown_prio         = q.shutdown_prio;
   assign class_event_flag      = q.class_event_flag;
   assign detection_event_flag  = q.detection_event_flag;
   assign power_good_clear      = q.power_good_clear;
   assign power_enable_clear    = q.power_enable_clear;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   sequence s_write_a;
      reg_wr && reg_cmd == CMD_GLOBAL_MASK && !access_width_select && !reg_group_b;
   endsequence

   sequence s_read_a;
      reg_rd && reg_cmd == CMD_GLOBAL_MASK && !access_width_select && !reg_group_b;
   endsequence

   sequence s_write_b;
      reg_wr && reg_cmd == CMD_GLOBAL_MASK && !access_width_select && reg_group_b;
   endsequence

   sequence s_write_wide;
      reg_wr && reg_cmd == CMD_GLOBAL_MASK && access_width_select;
   endsequence

   sequence s_read_wide;
      reg_rd && reg_cmd == CMD_GLOBAL_MASK && access_width_select;
   endsequence

   a_fault_clears_power: assert property (
      |faults |=> (power_good_clear == $past(faults.current_limit_timeout_fault
         | faults.overload_timeout_fault | faults.maintain_power_dropout_fault
         | faults.startup_timeout_fault)) && (power_enable_clear == power_good_clear))
      else $error("power clear does not follow fault");

   a_write_read_back: assert property (
      s_write_a ##1 s_read_a |=> reg_rvalid && reg_rdata[7:0] == $past(reg_wdata[7:0], 2))
      else $error("mask byte did not read back");

   a_gate_blocks_irq: assert property (
      (!q.mask_a[BIT_IRQ_GATE] && !q.mask_b[BIT_IRQ_GATE]) |=> irq_n)
      else $error("interrupt pin active with gate closed");

   a_events_ungated: assert property (
      (!q.mask_a[BIT_IRQ_GATE] && !q.mask_a[BIT_CLASS_FILT] && class_report.done[0])
      |=> class_event_flag[0])
      else $error("class event lost while gate closed");

   a_irq_asserts: assert property (
      (q.mask_a[BIT_IRQ_GATE] && |(irq_source[7:0] & irq_enable[7:0])) |=> !irq_n)
      else $error("unmasked source did not raise interrupt");

   a_wide_switch: assert property (
      s_write_a ##0 reg_wdata[BIT_ACCESS_WIDTH] |=> access_width_select)
      else $error("width bit of first instance did not switch mode");

   a_prio_select: assert property (
      q.mask_a[BIT_PRIO_WIDTH] |=> shutdown_prio[0] == $past(prio_3bit[0]))
      else $error("3-bit priority not selected");

   a_prio_one_bit: assert property (
      !q.mask_a[BIT_PRIO_WIDTH] |=> shutdown_prio[0] == {2'b00, $past(prio_1bit[0])})
      else $error("1-bit priority not selected");

   a_class_filter: assert property (
      (q.mask_a[BIT_CLASS_FILT] && q.class_seen[0] && class_report.done[0]
       && class_report.result[0] == q.prev_class[0]) |=> !class_event_flag[0])
      else $error("class flag set without change");

   a_det_every: assert property (
      (!q.mask_a[BIT_DET_FILT] && det_report.done[1]) |=> detection_event_flag[1])
      else $error("detection flag missed a cycle");

   a_det_filter: assert property (
      (q.mask_a[BIT_DET_FILT] && q.det_seen[0] && det_report.done[0]
       && det_report.result[0] != q.prev_det[0]) |=> detection_event_flag[0])
      else $error("detection change not flagged");

   // Per-group gating, refusals and the wide access path
   a_gate_b_blocks: assert property (
      (!q.mask_b[BIT_IRQ_GATE] && !(q.mask_a[BIT_IRQ_GATE]
       && |(irq_source[7:0] & irq_enable[7:0]))) |=> irq_n)
      else $error("group b source raised pin with its gate closed");

   a_irq_group_b: assert property (
      (q.mask_b[BIT_IRQ_GATE] && |(irq_source[15:8] & irq_enable[15:8])) |=> !irq_n)
      else $error("unmasked group b source did not raise interrupt");

   a_irq_quiet: assert property (
      !(|(irq_source & irq_enable)) |=> irq_n)
      else $error("interrupt pin active with no enabled source");

   a_read_answers: assert property (
      (reg_rd && reg_cmd == CMD_GLOBAL_MASK) |=> reg_rvalid)
      else $error("mask read not answered");

   a_read_refused: assert property (
      (reg_rd && reg_cmd != CMD_GLOBAL_MASK) |=> !reg_rvalid)
      else $error("foreign command answered");

   a_write_group_b: assert property (
      s_write_b |=> q.mask_b == $past(reg_wdata[7:0]) && q.mask_a == $past(q.mask_a))
      else $error("group b write landed in the wrong instance");

   a_narrow_read_hi: assert property (
      s_read_a |=> reg_rdata[15:8] == 8'h00)
      else $error("narrow read upper byte not zero");

   a_wide_write: assert property (
      s_write_wide |=> {q.mask_b, q.mask_a} == $past(reg_wdata))
      else $error("wide write did not fill both bytes");

   a_wide_read: assert property (
      s_read_wide |=> reg_rvalid && reg_rdata == $past({q.mask_b, q.mask_a}))
      else $error("wide read did not return both bytes");

   a_class_every: assert property (
      (!q.mask_a[BIT_CLASS_FILT] && class_report.done[2]) |=> class_event_flag[2])
      else $error("class flag missed a cycle");

   a_prio_group_b: assert property (
      q.mask_b[BIT_PRIO_WIDTH] |=> shutdown_prio[7] == $past(prio_3bit[7]))
      else $error("3-bit priority not selected for group b");

endmodule : pse_general_mask_config

// ### bench/host_model.sv
// Host model: drives the command-code register port like the serial controller.
// Assumes callers enter its tasks just after a rising edge of sys_clk.
`timescale 1ns/1ps

module host_model
(
   // Clock
   input  wire logic        sys_clk,
   // Register port
   output      logic        reg_wr,
   output      logic        reg_rd,
   output      logic [7:0]  reg_cmd,
   output      logic        reg_group_b,
   output      logic [15:0] reg_wdata,
   input  wire logic [15:0] reg_rdata,
   input  wire logic        reg_rvalid
);
   logic [15:0] got;
   logic        ok;

   ////////////////////////////////////////////////////////////////////////////
   // Idle bus at time zero
   initial
   begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_cmd = 8'h00;
      reg_group_b = 1'b0;
      reg_wdata = 16'h0000;
   end

   // Write held to the taking edge; a spare cycle keeps strobes apart
   task automatic wr(input logic [7:0] c, input logic g, input logic [15:0] d);
      reg_cmd = c;
      reg_group_b = g;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_wr = 1'b0;
      reg_wdata = ~d; // Stale data is not trusted
      @(posedge sys_clk);
      #1;
   endtask : wr

   // Read answer is registered, so it is seen just after the taking edge
   task automatic rd(input logic [7:0] c, input logic g);
      reg_cmd = c;
      reg_group_b = g;
      reg_rd = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_rd = 1'b0;
      ok = reg_rvalid;
      got = reg_rdata;
      @(posedge sys_clk);
      #1;
   endtask : rd

   // Write then read back at the very next edge, the tightest legal order
   task automatic wr_rd(input logic [7:0] c, input logic g, input logic [15:0] d);
      reg_cmd = c;
      reg_group_b = g;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_wr = 1'b0;
      reg_rd = 1'b1;
      reg_wdata = ~d;
      @(posedge sys_clk);
      #1;
      reg_rd = 1'b0;
      ok = reg_rvalid;
      got = reg_rdata;
      @(posedge sys_clk);
      #1;
   endtask : wr_rd
endmodule : host_model

// ### bench/testbench.sv
// Self-checking bench for the global mask and configuration block.
// Assumes the host model owns the register port; the bench drives the rest.
`timescale 1ns/1ps

module testbench
   import pse_mask_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic reg_wr, reg_rd, reg_group_b, reg_rvalid, irq_n, wide;
   logic [7:0] reg_cmd, va, vb, sc = '0, sd = '0, ec, ed, fc;
   logic [15:0] reg_wdata, reg_rdata, irq_source = '0, irq_enable = '0;
   logic access_width_select, priority_width_select;
   logic [NUM_CH-1:0] prio_1bit = '0, class_event_flag, detection_event_flag;
   logic [NUM_CH-1:0] power_good_clear, power_enable_clear;
   logic [NUM_CH-1:0][2:0] prio_3bit = '0, shutdown_prio;
   report_t class_report = '0, det_report = '0;
   fault_t faults = '0;
   logic [31:0] seed = 32'h36f284b2, pc = '0, pd = '0;
   int n_mismatch = 0, comparisons = 0, cyc = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Clock, free-running random source, hang guard
   always #12.5 sys_clk = ~sys_clk;
   // Next LFSR state; the fixed start keeps every run identical
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   always @(posedge sys_clk) seed <= lfsr(seed);
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_mismatch++;
         test_done();
      end
   end

   host_model host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_cmd(reg_cmd),
      .reg_group_b(reg_group_b), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid));
   pse_general_mask_config dut (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_cmd(reg_cmd), .reg_group_b(reg_group_b),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .irq_source(irq_source), .irq_enable(irq_enable), .irq_n(irq_n),
      .access_width_select(access_width_select), .prio_1bit(prio_1bit),
      .prio_3bit(prio_3bit), .priority_width_select(priority_width_select),
      .shutdown_prio(shutdown_prio), .class_report(class_report), .det_report(det_report),
      .class_event_flag(class_event_flag), .detection_event_flag(detection_event_flag),
      .faults(faults), .power_good_clear(power_good_clear),
      .power_enable_clear(power_enable_clear));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic test_done();
      $display("counts: mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : test_done

   // Selected priority per channel
   function automatic logic [23:0] exp_prio(input logic m, input logic [7:0] p1,
                                            input logic [23:0] p3);
      logic [23:0] r;
      for (int c = 0; c < 8; c++)
         r[3*c +: 3] = m ? p3[3*c +: 3] : {2'b00, p1[c]};
      return r;
   endfunction : exp_prio

   // Event pulse unless filtered and unchanged since an earlier report
   function automatic logic [7:0] exp_ev(input logic [7:0] d, input logic [31:0] r,
      input logic [31:0] p, input logic [7:0] s, input logic fa, input logic fb);
      logic [7:0] e;
      for (int c = 0; c < 8; c++)
         e[c] = d[c] && (!(c < 4 ? fa : fb) || !s[c] || r[4*c +: 4] != p[4*c +: 4]);
      return e;
   endfunction : exp_ev

   // Nibble mask of the channels that reported
   function automatic logic [31:0] nib(input logic [7:0] d);
      for (int c = 0; c < 8; c++)
         nib[4*c +: 4] = {4{d[c]}};
   endfunction : nib

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (5) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      // Reset values of both instances and the idle pin
      for (int g = 0; g < 2; g++)
      begin
         host.rd(CMD_GLOBAL_MASK, g[0]);
         check("mask_reset", host.got, {8'h00, MASK_RESET});
         check("rvalid", host.ok, 1'b1);
      end
      check("irq_idle", irq_n, 1'b1);
      host.rd(8'h16, 1'b0);
      check("foreign_cmd", host.ok, 1'b0);
      $display("test reset done");
      // Random masks; no shutdown stream runs, so priority switching is safe
      for (int i = 0; i < 24; i++)
      begin
         wide = (i >= 12);
         va = seed[7:0];
         vb = seed[15:8];
         va[BIT_ACCESS_WIDTH] = wide;
         vb[BIT_PRIO_WIDTH] = va[BIT_PRIO_WIDTH];
         if (wide)
         begin
            host.wr(CMD_GLOBAL_MASK, 1'b0, {vb, va});
            host.wr(CMD_GLOBAL_MASK, 1'b0, {vb, va});
            host.rd(CMD_GLOBAL_MASK, 1'b1);
            check("mask_wide", host.got, {vb, va});
         end
         else
         begin
            host.wr(CMD_GLOBAL_MASK, 1'b1, {8'h00, vb});
            host.wr_rd(CMD_GLOBAL_MASK, 1'b0, {8'h00, va});
            check("mask_a", host.got, {8'h00, va});
            check("rvalid_b2b", host.ok, 1'b1);
            host.rd(CMD_GLOBAL_MASK, 1'b1);
            check("mask_b", host.got, {8'h00, vb});
         end
         check("width", access_width_select, wide);
         check("prio_sel", priority_width_select, va[BIT_PRIO_WIDTH]);
         irq_source = seed[15:0];
         irq_enable = seed[31:16];
         prio_1bit = seed[23:16];
         prio_3bit = seed[23:0] ^ 24'h5a5a5a;
         class_report = {seed[7:0], seed & 32'h11111111};
         det_report = {seed[15:8], seed & 32'h22222222};
         faults = {seed[31:16] & seed[15:0], seed[15:0] & seed[31:16]};
         ec = exp_ev(seed[7:0], seed & 32'h11111111, pc, sc, va[3], vb[3]);
         ed = exp_ev(seed[15:8], seed & 32'h22222222, pd, sd, va[2], vb[2]);
         fc = faults[31:24] | faults[23:16] | faults[15:8] | faults[7:0];
         @(posedge sys_clk);
         #1;
         check("irq", irq_n, !(|(irq_source & irq_enable & {{8{vb[7]}}, {8{va[7]}}})));
         check("prio", shutdown_prio, exp_prio(va[4], prio_1bit, prio_3bit));
         check("class_ev", class_event_flag, ec);
         check("det_ev", detection_event_flag, ed);
         check("pg_clr", power_good_clear, fc);
         check("pe_clr", power_enable_clear, fc);
         pc = (pc & ~nib(class_report.done)) | (class_report.result & nib(class_report.done));
         pd = (pd & ~nib(det_report.done)) | (det_report.result & nib(det_report.done));
         sc |= class_report.done;
         sd |= det_report.done;
         class_report = '0;
         det_report = '0;
         faults = '0;
      end
      $display("test random masks done");
      test_done();
   end
endmodule : testbench
